// *** sensor_regs_pkg.sv ***
// Shared constants and carriers for the sensor result and status register bank
package sensor_regs_pkg;

  // Register byte addresses
  localparam logic [7:0]  ADDR_POWER_CMD   = 8'h22;
  localparam logic [7:0]  ADDR_TEMP_RESULT = 8'h2E;
  localparam logic [7:0]  ADDR_PRESS_RESULT = 8'h30;
  localparam logic [7:0]  ADDR_SNAPSHOT    = 8'h32;
  localparam logic [7:0]  ADDR_LIVE        = 8'h36;

  // Power command codes and the clear-all write pattern
  localparam logic [15:0] CMD_SLEEP        = 16'h6C32;
  localparam logic [15:0] CMD_RESET        = 16'hB169;
  localparam logic [15:0] CLEAR_ALL        = 16'hFFFF;

  // Status field positions
  localparam int          BIT_IDLE         = 0;
  localparam int          BIT_PRESS_NEW    = 3;
  localparam int          BIT_TEMP_NEW     = 4;
  localparam int          BIT_SUPPLY_FAULT = 7;
  localparam int          BIT_CHECK_FAULT  = 8;
  localparam int          BIT_SATURATED    = 10;
  localparam int          BIT_COM_CRC      = 11;
  localparam int          BIT_PRESS_MISSED = 14;
  localparam int          BIT_TEMP_MISSED  = 15;

  // Field classes; everything else is reserved
  localparam logic [15:0] EVENT_MASK       = 16'hC998;
  localparam logic [15:0] LEVEL_MASK       = 16'h0401;
  localparam logic [15:0] MIRROR_MASK      = 16'hFFE1;

  // Values after reset
  localparam logic [15:0] FLAGS_RESET      = 16'h0000;
  localparam logic [15:0] RESULT_RESET     = 16'h0000;
  localparam logic [15:0] RDATA_RESET      = 16'h0000;

  // One word access from the serial link
  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } link_access_t;

  // One corrected measurement from the datapath
  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } measurement_t;

endpackage : sensor_regs_pkg

// *** sensor_result_status_regs.sv ***
// Result and status register bank with a link-clock word access port
`timescale 1ns/100ps

module sensor_result_status_regs
  import sensor_regs_pkg::*;
(
  // Core clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  // Link side word access
  input  wire logic                          link_clk,
  input  wire logic                          link_req,
  input  wire sensor_regs_pkg::link_access_t link_cmd,
  output logic                               link_busy,
  output logic                               link_ack,
  output logic                               link_err,
  output logic [15:0]                        link_rdata,
  // Measurement datapath
  input  wire sensor_regs_pkg::measurement_t temp_meas,
  input  wire sensor_regs_pkg::measurement_t press_meas,
  input  wire logic                          config_crc_fail,
  input  wire logic                          write_unlock,
  // Hardware conditions and faults
  input  wire logic                          chip_idle,
  input  wire logic                          dsp_saturated,
  input  wire logic                          bridge_supply_fault,
  input  wire logic                          bridge_check_fault,
  input  wire logic                          com_crc_error,
  // Power control
  output logic                               sleep_mode,
  output logic                               reload_req
);
  import sensor_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic is_readable(input logic [7:0] a);
    is_readable = (a == ADDR_TEMP_RESULT) || (a == ADDR_PRESS_RESULT) ||
                  (a == ADDR_SNAPSHOT) || (a == ADDR_LIVE);
  endfunction : is_readable

  function automatic logic is_writable(input logic [7:0] a, input logic unlocked);
    is_writable = (a == ADDR_POWER_CMD) || (a == ADDR_LIVE) ||
                  (unlocked && (a == ADDR_SNAPSHOT));
  endfunction : is_writable

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: reset sync, request capture, answer capture

  logic         link_rst_meta;
  logic         link_rst_r;
  logic         link_busy_r;
  logic         req_tgl_r;
  link_access_t link_hold_r;
  logic         ack_meta;
  logic         ack_sync_r;
  logic         ack_seen_r;
  logic         link_ack_r;
  logic         link_err_r;
  logic [15:0]  link_rdata_r;
  logic         ack_edge;
  logic         ack_tgl_r;
  logic         resp_err_r;
  logic [15:0]  resp_data_r;

  always_ff @(posedge link_clk) begin
    link_rst_meta <= srst;
    link_rst_r    <= link_rst_meta;
  end

  assign ack_edge = ack_sync_r ^ ack_seen_r;

  always_ff @(posedge link_clk) begin
    if (link_rst_r) begin
      ack_meta   <= 1'b0;
      ack_sync_r <= 1'b0;
      ack_seen_r <= 1'b0;
    end else begin
      ack_meta   <= ack_tgl_r;
      ack_sync_r <= ack_meta;
      ack_seen_r <= ack_sync_r;
    end
  end

  // Request word is held stable while busy so the core can read it directly
  always_ff @(posedge link_clk) begin
    if (link_rst_r) begin
      link_busy_r <= 1'b0;
      req_tgl_r   <= 1'b0;
      link_hold_r <= '0;
    end else if (link_req && !link_busy_r) begin
      link_busy_r <= 1'b1;
      req_tgl_r   <= ~req_tgl_r;
      link_hold_r <= link_cmd;
    end else if (ack_edge) begin
      link_busy_r <= 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_r) begin
      link_ack_r   <= 1'b0;
      link_err_r   <= 1'b0;
      link_rdata_r <= RDATA_RESET;
    end else begin
      link_ack_r <= ack_edge;
      if (ack_edge) begin
        link_err_r   <= resp_err_r;
        link_rdata_r <= resp_data_r;
      end
    end
  end

  assign link_busy  = link_busy_r;
  assign link_ack   = link_ack_r;
  assign link_err   = link_err_r;
  assign link_rdata = link_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: request arrival

  logic        req_meta;
  logic        req_sync_r;
  logic        req_seen_r;
  logic        fire;
  logic        aligned;
  logic        refused;
  logic        do_write;
  logic        do_read;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      req_meta   <= 1'b0;
      req_sync_r <= 1'b0;
      req_seen_r <= 1'b0;
    end else begin
      req_meta   <= req_tgl_r;
      req_sync_r <= req_meta;
      req_seen_r <= req_sync_r;
    end
  end

  assign fire     = req_sync_r ^ req_seen_r;
  assign aligned  = ~link_hold_r.addr[0];
  assign refused  = !aligned || (link_hold_r.we ?
                    !is_writable(link_hold_r.addr, write_unlock) :
                    !is_readable(link_hold_r.addr));
  assign do_write = fire && link_hold_r.we && !refused;
  assign do_read  = fire && !link_hold_r.we && !refused;

  logic wr_cmd;
  logic wr_live;
  logic rd_temp;
  logic rd_press;

  assign wr_cmd   = do_write && (link_hold_r.addr == ADDR_POWER_CMD);
  assign wr_live  = do_write && (link_hold_r.addr == ADDR_LIVE);
  assign rd_temp  = do_read && (link_hold_r.addr == ADDR_TEMP_RESULT);
  assign rd_press = do_read && (link_hold_r.addr == ADDR_PRESS_RESULT);

  ////////////////////////////////////////////////////////////////////////////
  // Power command

  logic sleep_r;
  logic reload_r;
  logic soft_rst;

  assign soft_rst = reload_r;

  always_ff @(posedge core_clk) begin
    if (srst || soft_rst) begin
      sleep_r <= 1'b0;
    end else if (wr_cmd && (link_hold_r.wdata == CMD_SLEEP)) begin
      sleep_r <= 1'b1;
    end
  end

  // Reload pulse also clears the bank, as a power-up would
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reload_r <= 1'b0;
    end else begin
      reload_r <= wr_cmd && (link_hold_r.wdata == CMD_RESET);
    end
  end

  assign sleep_mode = sleep_r;
  assign reload_req = reload_r;

  ////////////////////////////////////////////////////////////////////////////
  // Result registers

  logic [15:0] temp_r;
  logic [15:0] press_r;
  logic        temp_load;
  logic        press_load;

  assign temp_load  = temp_meas.valid && !config_crc_fail;
  assign press_load = press_meas.valid && !config_crc_fail;

  // Contents read RESULT_RESET until the first load; no valid bit is kept
  always_ff @(posedge core_clk) begin
    if (srst || soft_rst) begin
      temp_r <= RESULT_RESET;
    end else if (temp_load) begin
      temp_r <= temp_meas.value;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || soft_rst) begin
      press_r <= RESULT_RESET;
    end else if (press_load) begin
      press_r <= press_meas.value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags

  logic [15:0] evt_r;
  logic [15:0] evt_set;
  logic [15:0] evt_clr;
  logic [15:0] live_flags;

  always_comb begin
    evt_set                   = FLAGS_RESET;
    evt_set[BIT_TEMP_NEW]     = temp_load;
    evt_set[BIT_PRESS_NEW]    = press_load;
    evt_set[BIT_SUPPLY_FAULT] = bridge_supply_fault;
    evt_set[BIT_CHECK_FAULT]  = bridge_check_fault;
    evt_set[BIT_COM_CRC]      = com_crc_error;
    evt_set[BIT_TEMP_MISSED]  = temp_load && evt_r[BIT_TEMP_NEW];
    evt_set[BIT_PRESS_MISSED] = press_load && evt_r[BIT_PRESS_NEW];
  end

  always_comb begin
    evt_clr                = wr_live ? link_hold_r.wdata : FLAGS_RESET;
    evt_clr[BIT_TEMP_NEW]  = evt_clr[BIT_TEMP_NEW] || rd_temp;
    evt_clr[BIT_PRESS_NEW] = evt_clr[BIT_PRESS_NEW] || rd_press;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_evt
      if (EVENT_MASK[gi]) begin : g_flag
        always_ff @(posedge core_clk) begin
          if (srst || soft_rst) begin
            evt_r[gi] <= FLAGS_RESET[gi];
          end else begin
            evt_r[gi] <= evt_set[gi] || (evt_r[gi] && !evt_clr[gi]);
          end
        end
      end else begin : g_rsvd
        // Kept procedural so every bit of the vector has one kind of driver
        always_ff @(posedge core_clk) begin
          evt_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Level flags come straight from hardware, so writes cannot touch them
  always_comb begin
    live_flags                = evt_r & EVENT_MASK;
    live_flags[BIT_IDLE]      = chip_idle;
    live_flags[BIT_SATURATED] = dsp_saturated;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot capture and read answer

  logic        snap_temp_r;
  logic        snap_press_r;
  logic [15:0] snap_flags;

  always_ff @(posedge core_clk) begin
    if (srst || soft_rst) begin
      snap_temp_r  <= 1'b0;
      snap_press_r <= 1'b0;
    end else begin
      if (rd_temp) begin
        snap_temp_r <= evt_r[BIT_TEMP_NEW];
      end
      if (rd_press) begin
        snap_press_r <= evt_r[BIT_PRESS_NEW];
      end
    end
  end

  always_comb begin
    snap_flags                = live_flags & MIRROR_MASK;
    snap_flags[BIT_TEMP_NEW]  = snap_temp_r;
    snap_flags[BIT_PRESS_NEW] = snap_press_r;
  end

  // Answer word is stable before the ack toggle leaves this domain
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_tgl_r   <= 1'b0;
      resp_err_r  <= 1'b0;
      resp_data_r <= RDATA_RESET;
    end else if (fire) begin
      ack_tgl_r  <= ~ack_tgl_r;
      resp_err_r <= refused;
      if (do_read) begin
        unique case (link_hold_r.addr)
          ADDR_TEMP_RESULT:  resp_data_r <= temp_r;
          ADDR_PRESS_RESULT: resp_data_r <= press_r;
          ADDR_SNAPSHOT:     resp_data_r <= snap_flags;
          default:           resp_data_r <= live_flags;
        endcase
      end else begin
        resp_data_r <= RDATA_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_live_write(logic [15:0] m);
    wr_live && ((link_hold_r.wdata & m) == m);
  endsequence

  sequence s_reload_pulse;
    reload_r ##1 !reload_r;
  endsequence

  temp_new_set_a: assert property (temp_load && !reload_r |=>
    evt_r[BIT_TEMP_NEW] && temp_r == $past(temp_meas.value))
    else $error("temperature load lost");
  press_new_set_a: assert property (press_load && !reload_r |=>
    evt_r[BIT_PRESS_NEW] && press_r == $past(press_meas.value))
    else $error("pressure load lost");
  crc_blocks_update_a: assert property (config_crc_fail && !reload_r |=>
    $stable(temp_r) && $stable(press_r)) else $error("result updated after config fail");
  write_protect_a: assert property (do_write |->
    link_hold_r.addr != ADDR_TEMP_RESULT && link_hold_r.addr != ADDR_PRESS_RESULT)
    else $error("write to protected result");
  sleep_cmd_a: assert property (wr_cmd && link_hold_r.wdata == CMD_SLEEP && !reload_r |=>
    sleep_mode) else $error("sleep not entered");
  reset_cmd_a: assert property (wr_cmd && link_hold_r.wdata == CMD_RESET |=>
    s_reload_pulse ##0 (evt_r == FLAGS_RESET)[*1] ##0 !sleep_mode)
    else $error("reset command not one pulse");
  read_clears_new_a: assert property (rd_temp && !temp_load && !reload_r |=>
    !evt_r[BIT_TEMP_NEW] && snap_temp_r == $past(evt_r[BIT_TEMP_NEW]))
    else $error("temperature read capture wrong");
  snap_mirror_a: assert property (do_read && link_hold_r.addr == ADDR_SNAPSHOT |=>
    (resp_data_r & MIRROR_MASK) == ($past(live_flags) & MIRROR_MASK))
    else $error("snapshot mirror mismatch");
  clear_all_a: assert property (s_live_write(CLEAR_ALL) ##0 evt_set == FLAGS_RESET |=>
    (live_flags & EVENT_MASK) == FLAGS_RESET) else $error("clear all failed");
  w1c_supply_a: assert property (s_live_write(16'h0080) ##0 !bridge_supply_fault |=>
    !evt_r[BIT_SUPPLY_FAULT]) else $error("supply fault not cleared");
  set_wins_a: assert property (wr_live && bridge_check_fault |=>
    evt_r[BIT_CHECK_FAULT] [*2]) else $error("clear beat set");
  missed_flag_a: assert property (press_load && evt_r[BIT_PRESS_NEW] && !reload_r |=>
    evt_r[BIT_PRESS_MISSED]) else $error("pressure overrun not flagged");
  level_track_a: assert property (do_read && link_hold_r.addr == ADDR_LIVE |=>
    resp_data_r[BIT_IDLE] == $past(chip_idle) &&
    resp_data_r[BIT_SATURATED] == $past(dsp_saturated)) else $error("level flag stale");
  reserved_zero_a: assert property (
    (live_flags & ~(EVENT_MASK | LEVEL_MASK)) == FLAGS_RESET) else $error("reserved bit set");

  odd_addr_err_a: assert property (@(posedge link_clk) disable iff (link_rst_r)
    ack_edge && link_hold_r.addr[0] |=> link_ack && link_err)
    else $error("odd address accepted");

endmodule : sensor_result_status_regs

// *** link_host_model.sv ***
// Behavioural link master issuing single word accesses
`timescale 1ns/100ps
module link_host_model
  import sensor_regs_pkg::*;
(
  // Link clock and answer
  input  wire logic                     link_clk,
  input  wire logic                     link_busy,
  input  wire logic                     link_ack,
  // Request
  output logic                          link_req,
  output sensor_regs_pkg::link_access_t link_cmd
);
  initial begin
    link_req = 1'b0;
    link_cmd = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One outstanding word; strobe held until taken, then answer awaited
  task automatic access(input logic we, input logic [7:0] addr, input logic [15:0] wdata);
    bit taken;
    taken = 1'b0;
    @(negedge link_clk);
    link_cmd = '{we: we, addr: addr, wdata: wdata};
    link_req = 1'b1;
    // Busy low at a falling edge means the next rising edge takes the word
    for (int i = 0; i < 80 && !taken; i++) begin
      taken = (link_busy === 1'b0);
      @(negedge link_clk);
    end
    link_req = 1'b0;
    // Released lines show the inverted word, not the last value
    link_cmd = ~link_cmd;
    for (int i = 0; i < 80 && link_ack !== 1'b1; i++) @(negedge link_clk);
  endtask : access
endmodule : link_host_model

// *** tb_top.sv ***
// Self-checking bench for the result and status register bank
`timescale 1ns/100ps
module tb_top;
  import sensor_regs_pkg::*;
  typedef struct packed { logic err; logic [15:0] data; } note_t;
  logic         core_clk, srst, link_clk, link_req, link_busy, link_ack, link_err;
  logic         config_crc_fail, write_unlock, chip_idle, dsp_saturated;
  logic         bridge_supply_fault, bridge_check_fault, com_crc_error;
  logic         sleep_mode, reload_req;
  logic [15:0]  link_rdata, t1, t3, p1;
  link_access_t link_cmd;
  measurement_t temp_meas, press_meas;
  note_t        q[$];
  note_t        n;
  int           fails, tests_run, reloads, cycles;

  sensor_result_status_regs i_dut (.core_clk(core_clk), .srst(srst), .link_clk(link_clk),
    .link_req(link_req), .link_cmd(link_cmd), .link_busy(link_busy), .link_ack(link_ack),
    .link_err(link_err), .link_rdata(link_rdata), .temp_meas(temp_meas),
    .press_meas(press_meas), .config_crc_fail(config_crc_fail), .write_unlock(write_unlock),
    .chip_idle(chip_idle), .dsp_saturated(dsp_saturated),
    .bridge_supply_fault(bridge_supply_fault), .bridge_check_fault(bridge_check_fault),
    .com_crc_error(com_crc_error), .sleep_mode(sleep_mode), .reload_req(reload_req));
  link_host_model i_host (.link_clk(link_clk), .link_busy(link_busy), .link_ack(link_ack),
    .link_req(link_req), .link_cmd(link_cmd));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    fails += q.size();
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic acc(input logic we, input logic [7:0] a, input logic [15:0] d,
                     input logic e, input logic [15:0] x);
    q.push_back('{err: e, data: x});
    i_host.access(we, a, d);
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    acc(1'b0, a, 16'h0000, 1'b0, x);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    acc(1'b1, a, d, 1'b0, 16'h0000);
  endtask : wr

  // Measurement load pulse of one core cycle
  task automatic load(input bit is_temp, input logic [15:0] val);
    @(negedge core_clk);
    if (is_temp) temp_meas = '{valid: 1'b1, value: val};
    else press_meas = '{valid: 1'b1, value: val};
    @(negedge core_clk);
    temp_meas.valid = 1'b0;
    press_meas.valid = 1'b0;
  endtask : load

  ////////////////////////////////////////////////////////////////////////////
  // Answer watcher: each ack retires the oldest note
  always @(negedge link_clk) begin
    if (link_ack === 1'b1) begin
      if (q.size() == 0) begin
        fails++;
        $display("CHECK FAILED link_ack expected none seen 1");
      end else begin
        n = q.pop_front();
        check("link_err", {15'h0000, link_err}, {15'h0000, n.err});
        if (!n.err) check("link_rdata", link_rdata, n.data);
      end
    end
  end

  always @(negedge core_clk) begin
    if (reload_req === 1'b1) reloads++;
    cycles++;
    if (cycles == 6000) begin
      fails++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    {temp_meas, press_meas} = '0;
    {config_crc_fail, write_unlock, chip_idle, dsp_saturated} = 4'h0;
    {bridge_supply_fault, bridge_check_fault, com_crc_error} = 3'h0;
    t1 = 16'($urandom(49078));
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    repeat (10) @(negedge core_clk);
    rd(ADDR_LIVE, FLAGS_RESET);
    rd(ADDR_TEMP_RESULT, RESULT_RESET);
    @(negedge core_clk) chip_idle = 1'b1;
    rd(ADDR_SNAPSHOT, 16'h0001);
    for (int i = 0; i < 3; i++) acc(1'b1, 8'h2E + 8'(2 * i), 16'hFFFF, 1'b1, 16'h0);
    acc(1'b0, ADDR_POWER_CMD, 16'h0, 1'b1, 16'h0);
    acc(1'b0, 8'h37, 16'h0, 1'b1, 16'h0);
    acc(1'b1, 8'h23, 16'h0, 1'b1, 16'h0);
    acc(1'b0, 8'h40, 16'h0, 1'b1, 16'h0);
    p1 = 16'($urandom);
    t3 = 16'($urandom);
    load(1, t1);
    load(0, p1);
    rd(ADDR_LIVE, 16'h0019);
    rd(ADDR_TEMP_RESULT, t1);
    rd(ADDR_PRESS_RESULT, p1);
    rd(ADDR_SNAPSHOT, 16'h0019);
    rd(ADDR_LIVE, 16'h0001);
    load(1, 16'($urandom));
    load(1, t3);
    rd(ADDR_LIVE, 16'h8011);
    rd(ADDR_TEMP_RESULT, t3);
    rd(ADDR_PRESS_RESULT, p1);
    rd(ADDR_SNAPSHOT, 16'h8011);
    load(0, 16'($urandom));
    load(0, 16'($urandom));
    rd(ADDR_LIVE, 16'hC009);
    @(negedge core_clk);
    {bridge_supply_fault, bridge_check_fault, com_crc_error, dsp_saturated} = 4'hF;
    @(negedge core_clk);
    {bridge_supply_fault, bridge_check_fault, com_crc_error} = 3'h0;
    rd(ADDR_LIVE, 16'hCD89);
    @(negedge core_clk) write_unlock = 1'b1;
    wr(ADDR_SNAPSHOT, CLEAR_ALL);
    rd(ADDR_LIVE, 16'hCD89);
    rd(ADDR_SNAPSHOT, 16'hCD91);
    wr(ADDR_LIVE, 16'h0481);
    rd(ADDR_LIVE, 16'hCD09);
    wr(ADDR_LIVE, CLEAR_ALL);
    rd(ADDR_LIVE, 16'h0401);
    @(negedge core_clk) dsp_saturated = 1'b0;
    rd(ADDR_LIVE, 16'h0001);
    // Fault held across the clear: set must win on every cycle
    @(negedge core_clk) bridge_check_fault = 1'b1;
    wr(ADDR_LIVE, CLEAR_ALL);
    rd(ADDR_LIVE, 16'h0101);
    @(negedge core_clk) bridge_check_fault = 1'b0;
    wr(ADDR_LIVE, 16'h0100);
    rd(ADDR_LIVE, 16'h0001);
    @(negedge core_clk) config_crc_fail = 1'b1;
    load(1, ~t3);
    rd(ADDR_TEMP_RESULT, t3);
    rd(ADDR_LIVE, 16'h0001);
    @(negedge core_clk) config_crc_fail = 1'b0;
    wr(ADDR_POWER_CMD, 16'($urandom) & 16'h00FF);
    @(negedge core_clk);
    check("sleep_mode", {15'h0000, sleep_mode}, 16'h0000);
    wr(ADDR_POWER_CMD, CMD_SLEEP);
    @(negedge core_clk);
    check("sleep_mode", {15'h0000, sleep_mode}, 16'h0001);
    load(1, t1);
    wr(ADDR_POWER_CMD, CMD_RESET);
    repeat (4) @(negedge core_clk);
    check("reload_req", 16'(reloads), 16'h0001);
    check("sleep_mode", {15'h0000, sleep_mode}, 16'h0000);
    rd(ADDR_TEMP_RESULT, RESULT_RESET);
    rd(ADDR_LIVE, 16'h0001);
    repeat (4) @(negedge core_clk);
    close_out();
  end
endmodule : tb_top
